/* File: ebus_mode_pkg.sv */
// Package: mode codes, per-mode bus configuration and transfer timing
`default_nettype none
package ebus_mode_pkg;

  // Eight operating modes in three classes
  typedef enum logic [2:0] {
    special_single_chip,
    emulation_narrow,
    special_test,
    emulation_wide,
    normal_single_chip,
    normal_narrow,
    special_peripheral,
    normal_wide
  } mode_e;

  // Mode pin codes, {mode_select_c, mode_select_b, mode_select_a}
  localparam logic [2:0] PINS_SPECIAL_SC  = 3'h0;
  localparam logic [2:0] PINS_EMUL_NARROW = 3'h1;
  localparam logic [2:0] PINS_SPECIAL_TST = 3'h2;
  localparam logic [2:0] PINS_EMUL_WIDE   = 3'h3;
  localparam logic [2:0] PINS_NORMAL_SC   = 3'h4;
  localparam logic [2:0] PINS_NORMAL_NAR  = 3'h5;
  localparam logic [2:0] PINS_SPECIAL_PER = 3'h6;

  // Port usage masks: a set bit is general-purpose I/O; in the two port E masks a set bit is a bus pin
  localparam logic [7:0] GPIO_ALL         = 8'hff;
  localparam logic [7:0] GPIO_NONE        = 8'h00;
  localparam logic [7:0] PORT_E_BUS_MASK  = 8'h9c;
  localparam logic [7:0] PORT_E_CLK_BIT   = 8'h10;

  // Reset values
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  // Bus clock output divider: half period in device clocks
  localparam int unsigned BUS_CLK_HALF    = 1;

  typedef struct packed {
    mode_e      mode;
    logic       addr_bus_en;
    logic       data_bus_en;
    logic       bus_ctrl_en;
    logic       data_wide;
    logic       clock_stretch;
    logic       chip_select_en;
    logic       bus_clock_out_en;
    logic       port_e_emul_write;
    logic       port_a_regs_mapped;
    logic       reduced_drive_mapped;
    logic       debug_rom_en;
    logic       extra_write_priv;
    logic [7:0] gpio_a;
    logic [7:0] gpio_b;
    logic [7:0] gpio_e;
    logic [7:0] gpio_k;
  } cfg_s;

  typedef struct packed {
    logic        strobe;
    logic        hi_byte;
    logic        done;
    logic [15:0] data;
  } beat_s;

  function automatic mode_e pins_to_mode(input logic [2:0] pins);
    unique case (pins)
      PINS_SPECIAL_SC:  pins_to_mode = special_single_chip;
      PINS_EMUL_NARROW: pins_to_mode = emulation_narrow;
      PINS_SPECIAL_TST: pins_to_mode = special_test;
      PINS_EMUL_WIDE:   pins_to_mode = emulation_wide;
      PINS_NORMAL_SC:   pins_to_mode = normal_single_chip;
      PINS_NORMAL_NAR:  pins_to_mode = normal_narrow;
      PINS_SPECIAL_PER: pins_to_mode = special_peripheral;
      default:          pins_to_mode = normal_wide;
    endcase
  endfunction

  function automatic logic is_emul(input mode_e m);
    is_emul = (m == emulation_narrow) || (m == emulation_wide);
  endfunction

  function automatic logic is_normal(input mode_e m);
    is_normal = (m == normal_single_chip) || (m == normal_narrow) ||
                (m == normal_wide);
  endfunction

  function automatic cfg_s mode_cfg(input mode_e m);
    cfg_s c;
    logic exp;
    c = '0;
    exp = (m == emulation_narrow) || (m == emulation_wide) ||
          (m == normal_narrow) || (m == normal_wide) ||
          (m == special_test) || (m == special_peripheral);
    c.mode                 = m;
    c.addr_bus_en          = exp;
    c.data_bus_en          = exp;
    c.bus_ctrl_en          = exp;
    c.data_wide            = (m == emulation_wide) || (m == normal_wide) ||
                             (m == special_test);
    c.clock_stretch        = exp;
    c.chip_select_en       = is_emul(m);
    c.bus_clock_out_en     = is_emul(m);
    c.port_e_emul_write    = is_emul(m);
    c.port_a_regs_mapped   = !is_emul(m);
    c.reduced_drive_mapped = !is_emul(m);
    c.debug_rom_en         = (m == special_single_chip);
    c.extra_write_priv     = (m == special_single_chip);
    c.gpio_a               = exp ? GPIO_NONE : GPIO_ALL;
    c.gpio_b               = exp ? GPIO_NONE : GPIO_ALL;
    c.gpio_k               = exp ? GPIO_NONE : GPIO_ALL;
    c.gpio_e               = exp ? ~PORT_E_BUS_MASK : GPIO_ALL;
    if (is_emul(m))
      c.gpio_e = c.gpio_e & ~PORT_E_CLK_BIT;
    mode_cfg = c;
  endfunction

endpackage
`default_nettype wire

/* File: external_bus_mode_config.sv */
// Operating mode selection and external expansion bus configuration
// Operation
// - Exactly one of eight modes, three classes
// - Emulation: bus control, stretch, chip select on
// - Emulation: port E bit4 drives bus clock
// - Emulation: port A and drive registers unmapped
// - Emulation modes grant no extra access rights
// - Special single-chip: write privileges, debug ROM
// - Normal modes: unused port pins stay GPIO
// - External bus in all modes except the two single-chip ones
// - Normal single-chip: no external address/data
// - Wide: 16-bit address and data buses
// - Normal expanded: stretch on, debug ROM off
// - Narrow: 16-bit data as two bytes
// - Port B: low address or GPIO
`default_nettype none
module external_bus_mode_config (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Mode pins, asynchronous
  input  wire logic                  mode_select_c,
  input  wire logic                  mode_select_b,
  input  wire logic                  mode_select_a,
  // Software mode switch
  input  wire logic                  sw_mode_write,
  input  wire ebus_mode_pkg::mode_e  sw_mode,
  // Transfer requests
  input  wire logic                  xfer_req,
  input  wire logic                  xfer_is16,
  input  wire logic [15:0]           xfer_data,
  // Configuration
  output var  ebus_mode_pkg::cfg_s   cfg,
  output var  logic                  cfg_valid,
  output var  logic                  sw_refused,
  // External bus side
  output var  logic                  bus_clock_out,
  output var  logic                  emulation_chip_select_n,
  output var  ebus_mode_pkg::beat_s  beat,
  output var  logic                  xfer_busy,
  output var  logic                  xfer_refused
);
  import ebus_mode_pkg::*;

  typedef enum logic {xf_idle, xf_low} xfer_state_e;

  // Pin synchronisers; not reset so pins are settled at release
  logic [2:0]  pins_meta;
  logic [2:0]  pins_sync;

  logic        captured;
  logic        next_captured;
  cfg_s        next_cfg;
  logic        next_cfg_valid;
  logic        next_sw_refused;
  logic        bus_clock_out_q;
  logic        next_bus_clock_out;
  xfer_state_e state;
  xfer_state_e next_state;
  beat_s       next_beat;
  logic [7:0]  low_byte;
  logic [7:0]  next_low_byte;
  logic        next_cs_n;
  logic        next_busy;
  logic        next_xfer_refused;
  logic        accept;
  logic        sw_ok;

  always_ff @(posedge clock) begin
    pins_meta <= {mode_select_c, mode_select_b, mode_select_a};
    pins_sync <= pins_meta;
  end

  // Switches stay inside a class, so emulation never loses its bus
  always_comb begin
    sw_ok = (is_normal(cfg.mode) && is_normal(sw_mode)) ||
            (is_emul(cfg.mode) && is_emul(sw_mode));
  end

  always_comb begin
    next_captured   = captured;
    next_cfg        = cfg;
    next_cfg_valid  = cfg_valid;
    next_sw_refused = 1'b0;
    if (!captured) begin
      next_captured  = 1'b1;
      next_cfg       = mode_cfg(pins_to_mode(pins_sync));
      next_cfg_valid = 1'b1;
    end else if (sw_mode_write) begin
      if (sw_ok && state == xf_idle)
        next_cfg = mode_cfg(sw_mode);
      else
        next_sw_refused = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      captured   <= 1'b0;
      cfg        <= mode_cfg(normal_single_chip);
      cfg_valid  <= 1'b0;
      sw_refused <= 1'b0;
    end else begin
      captured   <= next_captured;
      cfg        <= next_cfg;
      cfg_valid  <= next_cfg_valid;
      sw_refused <= next_sw_refused;
    end
  end

  // Bus clock on port E bit 4 only where the mode gives it
  always_comb begin
    next_bus_clock_out = 1'b0;
    if (cfg_valid && cfg.bus_clock_out_en)
      next_bus_clock_out = !bus_clock_out_q;
  end

  always_ff @(posedge clock) begin
    if (rst)
      bus_clock_out_q <= 1'b0;
    else
      bus_clock_out_q <= next_bus_clock_out;
  end
  assign bus_clock_out = bus_clock_out_q;

  // Transfers: wide is one beat, narrow 16-bit is high then low byte
  always_comb begin
    accept = xfer_req && cfg_valid && cfg.data_bus_en && state == xf_idle;
  end

  always_comb begin
    next_state        = state;
    next_beat         = '0;
    next_low_byte     = low_byte;
    next_cs_n         = 1'b1;
    next_busy         = 1'b0;
    next_xfer_refused = xfer_req && !accept;
    unique case (state)
      xf_idle: begin
        if (accept) begin
          next_beat.strobe = 1'b1;
          next_cs_n        = !cfg.chip_select_en;
          if (cfg.data_wide) begin
            next_beat.data = xfer_data;
            next_beat.done = 1'b1;
          end else if (xfer_is16) begin
            next_beat.data    = {BYTE_ZERO, xfer_data[15:8]};
            next_beat.hi_byte = 1'b1;
            next_low_byte     = xfer_data[7:0];
            next_state        = xf_low;
            next_busy         = 1'b1;
          end else begin
            next_beat.data = {BYTE_ZERO, xfer_data[7:0]};
            next_beat.done = 1'b1;
          end
        end
      end
      xf_low: begin
        next_beat.strobe = 1'b1;
        next_beat.done   = 1'b1;
        next_beat.data   = {BYTE_ZERO, low_byte};
        next_cs_n        = !cfg.chip_select_en;
        next_state       = xf_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state                   <= xf_idle;
      beat                    <= '0;
      low_byte                <= BYTE_ZERO;
      emulation_chip_select_n <= 1'b1;
      xfer_busy               <= 1'b0;
      xfer_refused            <= 1'b0;
    end else begin
      state                   <= next_state;
      beat                    <= next_beat;
      low_byte                <= next_low_byte;
      emulation_chip_select_n <= next_cs_n;
      xfer_busy               <= next_busy;
      xfer_refused            <= next_xfer_refused;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_EMUL_STARTUP: assert property (
    cfg_valid && is_emul(cfg.mode) |->
      cfg.bus_ctrl_en && cfg.clock_stretch && cfg.chip_select_en)
    else $error("emulation mode without bus control or chip select");
  AST_EMUL_CLOCK: assert property (
    cfg_valid && is_emul(cfg.mode) |=> !is_emul(cfg.mode) ||
      ((bus_clock_out != $past(bus_clock_out)) && !cfg.gpio_e[4]))
    else $error("bus clock not toggling in emulation mode");
  AST_EMUL_UNMAP: assert property (
    is_emul(cfg.mode) |->
      !cfg.port_a_regs_mapped && !cfg.reduced_drive_mapped)
    else $error("port A registers mapped in emulation mode");
  AST_EMUL_NO_PRIV: assert property (
    is_emul(cfg.mode) |-> !cfg.extra_write_priv && !cfg.debug_rom_en)
    else $error("emulation mode grants extra rights");
  AST_SPECIAL_SC: assert property (
    cfg.mode == special_single_chip && cfg_valid |->
      cfg.extra_write_priv && cfg.debug_rom_en && !cfg.addr_bus_en)
    else $error("special single-chip without debug support");
  AST_NORMAL_BUS: assert property (
    is_normal(cfg.mode) |->
      cfg.addr_bus_en == (cfg.mode != normal_single_chip))
    else $error("normal mode bus presence wrong");
  AST_NO_BUS_XFER: assert property (
    cfg_valid && !cfg.data_bus_en && xfer_req |=>
      xfer_refused && !beat.strobe)
    else $error("transfer accepted without a data bus");
  AST_WIDE_BUS: assert property (
    accept && cfg.data_wide |=> beat.strobe && beat.done &&
      beat.data == $past(xfer_data) && !xfer_busy)
    else $error("wide transfer not one full beat");
  AST_NARROW_SPLIT: assert property (
    accept && !cfg.data_wide && xfer_is16 |=>
      beat.strobe && beat.hi_byte && !beat.done && xfer_busy ##1
      beat.strobe && !beat.hi_byte && beat.done && !xfer_busy)
    else $error("narrow 16-bit transfer not split in two bytes");
  AST_NORMAL_EXP: assert property (
    cfg.mode == normal_wide || cfg.mode == normal_narrow |->
      cfg.clock_stretch && !cfg.debug_rom_en)
    else $error("normal expanded defaults wrong");
  AST_GPIO: assert property (
    is_normal(cfg.mode) |-> cfg.gpio_e ==
      (cfg.bus_ctrl_en ? ~PORT_E_BUS_MASK : GPIO_ALL))
    else $error("unused port E pins not left as GPIO");
  AST_PORT_B: assert property (
    cfg.gpio_b == (cfg.addr_bus_en ? GPIO_NONE : GPIO_ALL))
    else $error("port B use does not follow mode");
  AST_MODE_HELD: assert property (
    cfg_valid && $past(cfg_valid) && !$past(sw_mode_write) |->
      $stable(cfg.mode))
    else $error("mode changed without a permitted switch");

  COV_EMUL: cover property (cfg_valid && cfg.mode == emulation_wide);
  COV_SPECIAL: cover property (cfg_valid &&
    cfg.mode == special_single_chip);
  COV_SPLIT: cover property (beat.strobe && beat.hi_byte);
  COV_SWITCH: cover property (cfg.mode == normal_single_chip ##1
    cfg.mode == normal_wide);
endmodule
`default_nettype wire

/* File: ext_mem_model.sv */
// Far-side memory model behind the demultiplexing latch
`default_nettype none
module ext_mem_model (
  // Clock and external bus
  input  wire logic                 clock,
  input  wire ebus_mode_pkg::beat_s beat,
  input  wire logic                 data_wide,
  input  wire logic                 chip_select_n,
  // Observations for the bench
  output var  int                   beats,
  output var  int                   hi_beats,
  output var  int                   cs_beats,
  output var  logic [15:0]          word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold;

  initial begin
    beats = 0;
    hi_beats = 0;
    cs_beats = 0;
    word = 16'h0000;
    hold = 8'h00;
  end

  // Latches each beat; narrow words rebuilt from two bytes
  always @(posedge clock) begin
    if (beat.strobe === 1'b1) begin
      beats <= beats + 1;
      if (chip_select_n === 1'b0)
        cs_beats <= cs_beats + 1;
      if (beat.hi_byte === 1'b1) begin
        hi_beats <= hi_beats + 1;
        hold <= beat.data[7:0];
      end
      if (beat.done === 1'b1) begin
        word <= data_wide ? beat.data : {hold, beat.data[7:0]};
        hold <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test_external_bus_mode_config.sv */
// Testbench for mode selection and external bus configuration
`default_nettype none
module test_external_bus_mode_config;
  timeunit 1ns;
  timeprecision 1ps;
  import ebus_mode_pkg::*;
  logic        clock, rst, mode_select_c, mode_select_b, mode_select_a;
  logic        sw_mode_write, xfer_req, xfer_is16;
  mode_e       sw_mode;
  logic [15:0] xfer_data, word;
  cfg_s        cfg;
  beat_s       beat;
  logic        cfg_valid, sw_refused, bus_clock_out, xfer_busy;
  logic        emulation_chip_select_n, xfer_refused;
  int          beats, hi_beats, cs_beats, b0, h0, c0, r0, s0, u0;
  int          failures = 0, n_checks = 0, cycles = 0;
  int          n_swref = 0, n_xref = 0, n_busy = 0;

  external_bus_mode_config DUT (.clock(clock), .rst(rst),
    .mode_select_c(mode_select_c), .mode_select_b(mode_select_b),
    .mode_select_a(mode_select_a), .sw_mode_write(sw_mode_write),
    .sw_mode(sw_mode), .xfer_req(xfer_req), .xfer_is16(xfer_is16),
    .xfer_data(xfer_data), .cfg(cfg), .cfg_valid(cfg_valid),
    .sw_refused(sw_refused), .bus_clock_out(bus_clock_out),
    .emulation_chip_select_n(emulation_chip_select_n), .beat(beat),
    .xfer_busy(xfer_busy), .xfer_refused(xfer_refused));
  ext_mem_model far_end (.clock(clock), .beat(beat),
    .data_wide(cfg.data_wide), .chip_select_n(emulation_chip_select_n),
    .beats(beats), .hi_beats(hi_beats), .cs_beats(cs_beats), .word(word));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Refusal pulses last one cycle, so count them at every edge
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (sw_refused === 1'b1) n_swref <= n_swref + 1;
    if (xfer_refused === 1'b1) n_xref <= n_xref + 1;
    if (xfer_busy === 1'b1) n_busy <= n_busy + 1;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Synchronisers are not reset, so pins are held through all 10 cycles
  task automatic do_reset(input logic [2:0] pins);
    @(posedge clock);
    rst <= 1'b1;
    {mode_select_c, mode_select_b, mode_select_a} <= pins;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk(16'(cfg_valid), 16'h1, "mode not captured");
  endtask

  task automatic sw(input mode_e t);
    s0 = n_swref;
    @(posedge clock);
    sw_mode_write <= 1'b1;
    sw_mode <= t;
    @(posedge clock);
    sw_mode_write <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic xf(input logic is16, input logic [15:0] d);
    b0 = beats;
    h0 = hi_beats;
    c0 = cs_beats;
    r0 = n_xref;
    u0 = n_busy;
    @(posedge clock);
    xfer_req <= 1'b1;
    xfer_is16 <= is16;
    xfer_data <= d;
    @(posedge clock);
    xfer_req <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  task automatic deltas(input int db, dh, dc, dr);
    chk(16'(beats - b0), 16'(db), "beat count");
    chk(16'(hi_beats - h0), 16'(dh), "high byte beats");
    chk(16'(cs_beats - c0), 16'(dc), "chip select beats");
    chk(16'(n_xref - r0), 16'(dr), "transfer refusals");
  endtask

  task automatic test_modes();
    mode_e m;
    logic  ex, em, wd, sp, b;
    logic [7:0] pe;
    for (int i = 0; i < 8; i++) begin
      m = mode_e'(i);
      do_reset(3'(i));
      em = (m == emulation_narrow) || (m == emulation_wide);
      ex = (m != special_single_chip) && (m != normal_single_chip);
      wd = (m == emulation_wide) || (m == normal_wide) || (m == special_test);
      sp = (m == special_single_chip);
      chk(16'(cfg.mode), 16'(m), "mode decode");
      chk(16'({cfg.addr_bus_en, cfg.data_bus_en, cfg.bus_ctrl_en}),
          16'({3{ex}}), "bus presence");
      chk(16'(cfg.data_wide), 16'(wd), "data width");
      chk(16'(cfg.clock_stretch), 16'(ex), "stretch");
      chk(16'({cfg.chip_select_en, cfg.bus_clock_out_en,
               cfg.port_e_emul_write}), 16'({3{em}}), "emul bus");
      chk(16'({cfg.port_a_regs_mapped, cfg.reduced_drive_mapped}),
          16'({2{!em}}), "port A map");
      chk(16'({cfg.debug_rom_en, cfg.extra_write_priv}), 16'({2{sp}}),
          "privileges");
      chk(16'(cfg.gpio_a), ex ? 16'h0000 : 16'h00ff, "port A use");
      chk(16'(cfg.gpio_b), ex ? 16'h0000 : 16'h00ff, "port B use");
      chk(16'(cfg.gpio_k), ex ? 16'h0000 : 16'h00ff, "port K use");
      pe = ex ? ~PORT_E_BUS_MASK : GPIO_ALL;
      if (em)
        pe = pe & ~PORT_E_CLK_BIT;
      chk(16'(cfg.gpio_e), 16'(pe), "port E use");
      b = bus_clock_out;
      @(posedge clock);
      #1 chk(16'({b, bus_clock_out}), em ? 16'({b, !b}) : 16'h0000,
             "bus clock");
    end
    $display("test_modes done");
  endtask

  task automatic test_hold();
    do_reset(3'h0);
    @(posedge clock);
    {mode_select_c, mode_select_b, mode_select_a} <= 3'h7;
    repeat (6) @(posedge clock);
    #1 chk(16'(cfg.mode), 16'(special_single_chip), "pins relatched");
    sw(normal_wide);
    chk(16'(n_swref - s0), 16'h1, "special switch");
    $display("test_hold done");
  endtask

  task automatic test_switch();
    do_reset(3'h4);
    sw(normal_wide);
    chk(16'(cfg.mode), 16'(normal_wide), "normal switch");
    chk(16'(n_swref - s0), 16'h0, "normal switch refused");
    sw(emulation_wide);
    chk(16'(cfg.mode), 16'(normal_wide), "class crossed");
    chk(16'(n_swref - s0), 16'h1, "cross refusal");
    $display("test_switch done");
  endtask

  task automatic test_xfers();
    do_reset(3'h5);
    xf(1'b1, 16'hbeef);
    deltas(2, 1, 0, 0);
    chk(word, 16'hbeef, "narrow word");
    chk(16'(n_busy - u0), 16'h1, "narrow busy cycles");
    xf(1'b0, 16'h12a5);
    deltas(1, 0, 0, 0);
    chk(word, 16'h00a5, "narrow byte");
    // Request held into the low-byte cycle is turned away there
    b0 = beats;
    h0 = hi_beats;
    c0 = cs_beats;
    r0 = n_xref;
    @(posedge clock);
    xfer_req <= 1'b1;
    xfer_is16 <= 1'b1;
    xfer_data <= 16'h0f1e;
    repeat (2) @(posedge clock);
    xfer_req <= 1'b0;
    repeat (4) @(posedge clock);
    #1 deltas(2, 1, 0, 1);
    chk(word, 16'h0f1e, "word beside refusal");
    do_reset(3'h3);
    xf(1'b1, 16'h5a3c);
    deltas(1, 0, 1, 0);
    chk(word, 16'h5a3c, "wide word");
    chk(16'(n_busy - u0), 16'h0, "wide busy cycles");
    do_reset(3'h1);
    xf(1'b1, 16'hc3d2);
    deltas(2, 1, 2, 0);
    chk(word, 16'hc3d2, "emulation narrow word");
    do_reset(3'h4);
    xf(1'b1, 16'h1234);
    deltas(0, 0, 0, 1);
    $display("test_xfers done");
  endtask

  initial begin
    rst = 1'b1;
    {mode_select_c, mode_select_b, mode_select_a} = 3'h4;
    sw_mode_write = 1'b0;
    sw_mode = normal_single_chip;
    xfer_req = 1'b0;
    xfer_is16 = 1'b0;
    xfer_data = 16'h0000;
    test_modes();
    test_hold();
    test_switch();
    test_xfers();
    close_out();
  end
endmodule
`default_nettype wire
